// *** verilog/serial_flash_aux_space_commands.sv ***
// Overview of operation
// - Opcode 5Ah, 24-bit address, 8 dummy clocks; bytes out from 40th fall.
// - Table read needs upper 16 address bits zero; low byte selects start.
// - Security erase accepted only with write latch flag set.
// - Erase 44h: top byte 00h, bits 15:12 pick register 1-3, 11:8 zero.
// - Erase runs only if chip select rises right after the last address bit.
// - Erase is self-timed after chip select rises; busy high until done.
// - Erase to a register whose one-time lock bit is set is ignored.
// - Program 42h writes 1 to 256 bytes into erased locations.
// - Program needs write latch flag; chip select stays low through data.
// - Program to a register whose one-time lock bit is set is ignored.
// - Read 48h: address and dummy in on rises, data MSB first on falls.
// - Read address advances per byte, wraps FFh to 00h until deselect.
// - Security read during busy operation is ignored; operation undisturbed.
// - Block lock bits protect only when select bit is one; else extent bits.
// - Block lock bits are volatile and all set to one after reset.
// - Lock 36h with 24-bit address then deselect sets that block's lock bit.
// - Block lock command accepted only with write latch flag set.
`timescale 1ns/1ps
module serial_flash_aux_space_commands
    import aux_flash_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_TIME_US * CLK_FREQ_MHZ
) (
    // clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    // serial link from host
    input  wire logic        I_CHIP_SELECT_N,
    input  wire logic        I_SERIAL_CLK,
    input  wire logic        I_SERIAL_IN_PIN,
    output logic             O_SERIAL_OUT,
    output logic             O_SERIAL_OUT_OE,
    // status bits
    input  wire logic        I_WRITE_LATCH_FLAG,
    input  wire logic [2:0]  I_OTP_LOCK_BITS,
    output logic             O_WRITE_LATCH_CLEAR,
    output logic             O_BUSY,
    // protection configuration and query
    input  wire logic        I_PER_REGION_PROTECT_SELECT,
    input  wire logic        I_PROTECT_COMPLEMENT,
    input  wire logic        I_SECTOR_GRANULARITY_BIT,
    input  wire logic        I_TOP_BOTTOM_SELECT,
    input  wire logic [2:0]  I_PROTECT_EXTENT_BITS,
    input  wire logic [23:0] I_CHECK_ADDR,
    output logic             O_CHECK_PROTECTED
);

    function automatic logic [1:0] sec_index(input logic [23:0] a);
        if (a[23:16] != 8'h00 || a[15:14] != 2'b00 || a[11:8] != 4'h0) begin
            return 2'd0;
        end
        return a[SEC_IDX_LSB +: 2];
    endfunction

    // table content: signature bytes, rest reads as erased
    function automatic logic [7:0] table_byte(input logic [7:0] a);
        case (a)
            8'h00:   return 8'h53;
            8'h01:   return 8'h46;
            8'h02:   return 8'h44;
            8'h03:   return 8'h50;
            default: return ERASED_BYTE;
        endcase
    endfunction

    function automatic logic extent_hit(input logic [23:0] a,
                                        input logic        fine,
                                        input logic        bottom,
                                        input logic [2:0]  ext);
        logic [8:0]  nblk;
        logic [12:0] nsec;
        logic [12:0] sidx;
        nblk = 9'd2 << ext;
        nsec = (ext >= 3'd4) ? 13'd8 : (13'd1 << (ext - 3'd1));
        sidx = {1'b0, a[23:12]};
        if (ext == 3'd0) begin
            return 1'b0;
        end
        if (!fine) begin
            return bottom ? ({1'b0, a[23:16]} < nblk)
                          : ({1'b0, a[23:16]} >= (9'd256 - nblk));
        end
        return bottom ? (sidx < nsec) : (sidx >= (13'd4096 - nsec));
    endfunction

    // link synchronisers
    logic cs_meta_r, cs_sync_r, cs_prev_r;
    logic sclk_meta_r, sclk_sync_r, sclk_prev_r;
    logic din_meta_r, din_sync_r;

    state_type      state_r, state_nxt;
    logic [5:0]     bit_cnt_r, cnt_nxt;
    logic [31:0]    shift_r;
    logic [7:0]     cmd_r;
    logic [1:0]     sidx_r;
    logic [7:0]     byte_addr_r;
    logic [7:0]     wr_addr_r;
    logic [7:0]     lock_blk_r;
    logic [7:0]     so_r;
    logic [2:0]     out_cnt_r;
    logic           oe_r;
    logic           busy_r;
    logic           wlc_r;
    logic           got_byte_r;
    logic           prot_r;
    logic [255:0]   lock_r;
    logic [23:0]    timer_r;

    sec_store_if sif ();

    // edges seen through the synchronised copies only
    wire sclk_rise = sclk_sync_r & ~sclk_prev_r & ~cs_sync_r;
    wire sclk_fall = ~sclk_sync_r & sclk_prev_r & ~cs_sync_r;
    wire cs_rise   = cs_sync_r & ~cs_prev_r;

    wire [5:0]  cnt_inc  = bit_cnt_r + 6'd1;
    wire [31:0] shift_in = {shift_r[30:0], din_sync_r};
    wire [23:0] a_in     = shift_in[23:0];
    wire [1:0]  sidx_in  = sec_index(a_in);

    wire in_cmd    = (state_r == ST_CMD);
    wire op_done   = in_cmd & sclk_rise & (cnt_inc == OPCODE_BITS);
    wire addr_done = in_cmd & sclk_rise & (cnt_inc == ADDR_END_BIT);
    wire op_known  = (shift_in[7:0] == OP_SFDP_READ)
                   | (shift_in[7:0] == OP_SEC_ERASE)
                   | (shift_in[7:0] == OP_SEC_PROG)
                   | (shift_in[7:0] == OP_SEC_READ)
                   | (shift_in[7:0] == OP_BLOCK_LOCK);

    wire [2:0] sel_onehot = {sidx_in == 2'd3, sidx_in == 2'd2,
                             sidx_in == 2'd1};
    wire sec_ok   = (sidx_in != 2'd0);
    wire otp_hit  = |(I_OTP_LOCK_BITS & sel_onehot);
    wire write_ok = sec_ok & I_WRITE_LATCH_FLAG & ~otp_hit;
    wire tbl_ok   = (a_in[23:8] == 16'h0000);

    // where a frame goes once its address is in
    state_type addr_state;
    assign addr_state =
        (cmd_r == OP_SFDP_READ) ? (tbl_ok ? ST_DUMMY : ST_IGNORE) :
        (cmd_r == OP_SEC_READ)  ? (sec_ok ? ST_DUMMY : ST_IGNORE) :
        (cmd_r == OP_SEC_PROG)  ? (write_ok ? ST_PROG : ST_IGNORE) :
        (cmd_r == OP_SEC_ERASE) ? (write_ok ? ST_ARMED : ST_IGNORE) :
        (I_WRITE_LATCH_FLAG ? ST_ARMED : ST_IGNORE);

    wire arm_fire = (state_r == ST_ARMED) & cs_rise;
    wire erase_go = arm_fire & (cmd_r == OP_SEC_ERASE);
    wire lock_go  = arm_fire & (cmd_r == OP_BLOCK_LOCK);

    wire fall_out  = (state_r == ST_OUT) & sclk_fall;
    wire load_byte = fall_out & (out_cnt_r == 3'd0);
    wire prog_bit  = (state_r == ST_PROG) & sclk_rise;
    wire prog_byte = prog_bit & (bit_cnt_r[2:0] == 3'd7);
    wire prog_end  = (state_r == ST_PROG) & cs_rise & got_byte_r;

    wire erase_wr   = (state_r == ST_ERASE)
                    & (timer_r < 24'(ERASE_SWEEP));
    wire erase_done = (state_r == ST_ERASE)
                    & (timer_r == 24'(ERASE_CYCLES - 1));

    // data buffer between the link and the store
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_dout;

    // store port is shared with read prefetch and the erase sweep
    wire drain_ready = (state_r != ST_OUT) & (state_r != ST_ERASE);
    wire drain_fire  = fifo_out_valid & drain_ready;
    // a full buffer drops the byte; at link speed it never fills
    wire push        = prog_byte & fifo_in_ready;

    wire [1:0] bank     = sidx_r - 2'd1;
    wire [7:0] mem_low  = erase_wr   ? timer_r[7:0] :
                          drain_fire ? wr_addr_r : byte_addr_r;
    wire       is_table = (cmd_r == OP_SFDP_READ);
    wire [7:0] src_byte = is_table ? table_byte(byte_addr_r) : sif.rdata;

    assign sif.addr  = {bank, mem_low};
    assign sif.we    = erase_wr | drain_fire;
    assign sif.prog  = ~erase_wr;
    assign sif.wdata = erase_wr ? ERASED_BYTE : fifo_dout;

    wire prot_nxt = I_PER_REGION_PROTECT_SELECT
        ? lock_r[I_CHECK_ADDR[BLOCK_LSB +: 8]]
        : (I_PROTECT_COMPLEMENT ^ extent_hit(I_CHECK_ADDR,
                                             I_SECTOR_GRANULARITY_BIT,
                                             I_TOP_BOTTOM_SELECT,
                                             I_PROTECT_EXTENT_BITS));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = bit_cnt_r;
        unique case (state_r)
            ST_IDLE: begin
                if (!cs_sync_r) begin
                    state_nxt = ST_CMD;
                    cnt_nxt   = 6'd0;
                end
            end
            ST_CMD: begin
                if (sclk_rise) begin
                    cnt_nxt = cnt_inc;
                end
                if (op_done && !op_known) begin
                    state_nxt = ST_IGNORE;
                end else if (addr_done) begin
                    state_nxt = addr_state;
                end
            end
            ST_DUMMY: begin
                if (sclk_rise) begin
                    cnt_nxt = cnt_inc;
                    if (cnt_inc == DUMMY_END_BIT) begin
                        state_nxt = ST_OUT;
                    end
                end
            end
            ST_OUT: begin
            end
            ST_IGNORE: begin
            end
            ST_PROG: begin
                if (sclk_rise) begin
                    cnt_nxt = cnt_inc;
                end
            end
            ST_ARMED: begin
                if (sclk_rise) begin
                    state_nxt = ST_IGNORE;
                end else if (cs_rise) begin
                    state_nxt = erase_go ? ST_ERASE : ST_IDLE;
                end
            end
            ST_ERASE: begin
                // frames during the erase are not seen at all
                if (erase_done) begin
                    state_nxt = cs_sync_r ? ST_IDLE : ST_IGNORE;
                end
            end
        endcase
        if (cs_rise && state_r != ST_ERASE && state_r != ST_ARMED) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cs_meta_r   <= 1'b1;
            cs_sync_r   <= 1'b1;
            cs_prev_r   <= 1'b1;
            sclk_meta_r <= 1'b0;
            sclk_sync_r <= 1'b0;
            sclk_prev_r <= 1'b0;
            din_meta_r  <= 1'b0;
            din_sync_r  <= 1'b0;
        end else begin
            cs_meta_r   <= I_CHIP_SELECT_N;
            cs_sync_r   <= cs_meta_r;
            cs_prev_r   <= cs_sync_r;
            sclk_meta_r <= I_SERIAL_CLK;
            sclk_sync_r <= sclk_meta_r;
            sclk_prev_r <= sclk_sync_r;
            din_meta_r  <= I_SERIAL_IN_PIN;
            din_sync_r  <= din_meta_r;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= 6'd0;
            shift_r   <= 32'h0000_0000;
            cmd_r     <= 8'h00;
            sidx_r    <= 2'd0;
            lock_blk_r <= 8'h00;
        end else begin
            state_r   <= state_nxt;
            bit_cnt_r <= cnt_nxt;
            if (sclk_rise) begin
                shift_r <= shift_in;
            end
            if (op_done) begin
                cmd_r <= shift_in[7:0];
            end
            if (addr_done) begin
                sidx_r     <= sidx_in;
                lock_blk_r <= a_in[BLOCK_LSB +: 8];
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            byte_addr_r <= 8'h00;
            so_r        <= 8'h00;
            out_cnt_r   <= 3'd0;
            oe_r        <= 1'b0;
        end else begin
            if (addr_done) begin
                byte_addr_r <= a_in[7:0];
            end else if (load_byte) begin
                byte_addr_r <= byte_addr_r + 8'd1;
            end
            if (load_byte) begin
                so_r <= src_byte;
            end else if (fall_out) begin
                so_r <= {so_r[6:0], 1'b0};
            end
            out_cnt_r <= (state_r != ST_OUT) ? 3'd0
                       : out_cnt_r + {2'b00, fall_out};
            oe_r      <= (state_nxt == ST_OUT);
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            wr_addr_r  <= 8'h00;
            got_byte_r <= 1'b0;
            timer_r    <= 24'h00_0000;
            busy_r     <= 1'b0;
            wlc_r      <= 1'b0;
        end else begin
            if (addr_done) begin
                wr_addr_r <= a_in[7:0];
            end else if (drain_fire) begin
                wr_addr_r <= wr_addr_r + 8'd1;
            end
            got_byte_r <= (state_r == ST_IDLE) ? 1'b0 : (got_byte_r | push);
            timer_r    <= (state_r == ST_ERASE) ? timer_r + 24'd1 : 24'd0;
            busy_r     <= (state_nxt == ST_ERASE);
            wlc_r      <= erase_go | lock_go | prog_end;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lock_r <= LOCK_RESET_VAL;
            prot_r <= 1'b1;
        end else begin
            if (lock_go) begin
                lock_r[lock_blk_r] <= 1'b1;
            end
            prot_r <= prot_nxt;
        end
    end

    byte_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (I_CLOCK),
        .i_resetn    (I_RESETN),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (shift_in[7:0]),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (drain_ready),
        .o_out_data  (fifo_dout)
    );

    sec_reg_store u_store (
        .i_clk    (I_CLOCK),
        .i_resetn (I_RESETN),
        .port     (sif.store)
    );

    assign O_SERIAL_OUT        = so_r[7];
    assign O_SERIAL_OUT_OE     = oe_r;
    assign O_WRITE_LATCH_CLEAR = wlc_r;
    assign O_BUSY              = busy_r;
    assign O_CHECK_PROTECTED   = prot_r;
endmodule

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_r [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_r, rd_ptr_r;
    logic [AW:0]      count_r;

    wire do_wr = i_in_valid & o_in_ready;
    wire do_rd = o_out_valid & i_out_ready;

    assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data  = buf_r[rd_ptr_r];

    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            buf_r[wr_ptr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(do_wr);
            rd_ptr_r <= rd_ptr_r + AW'(do_rd);
            count_r  <= count_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// *** common/aux_flash_pkg.sv ***
package aux_flash_pkg;

    // opcodes
    localparam logic [7:0] OP_SFDP_READ  = 8'h5A;
    localparam logic [7:0] OP_SEC_ERASE  = 8'h44;
    localparam logic [7:0] OP_SEC_PROG   = 8'h42;
    localparam logic [7:0] OP_SEC_READ   = 8'h48;
    localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;

    // frame bit counts (rising clock edges)
    localparam logic [5:0] OPCODE_BITS   = 6'd8;
    localparam logic [5:0] ADDR_END_BIT  = 6'd32;
    localparam logic [5:0] DUMMY_END_BIT = 6'd40;

    // address fields
    localparam int SEC_IDX_LSB = 12;
    localparam int BLOCK_LSB   = 16;

    // erased and reset values
    localparam logic [7:0]   ERASED_BYTE    = 8'hFF;
    localparam logic [255:0] LOCK_RESET_VAL = {256{1'b1}};

    // timing
    localparam int CLK_FREQ_MHZ  = 20;
    localparam int ERASE_TIME_US = 1000;
    localparam int ERASE_SWEEP   = 256;

    // data buffer
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_DUMMY,
        ST_OUT,
        ST_PROG,
        ST_ARMED,
        ST_IGNORE,
        ST_ERASE
    } state_type;

endpackage

// *** common/sec_store_if.sv ***
`timescale 1ns/1ps
interface sec_store_if;
    logic [9:0] addr;
    logic       we;
    logic       prog;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl  (output addr, we, prog, wdata, input rdata);
    modport store (input addr, we, prog, wdata, output rdata);
endinterface

// *** verilog/sec_reg_store.sv ***
`timescale 1ns/1ps
module sec_reg_store (
    // clock and reset
    input wire logic    i_clk,
    input wire logic    i_resetn,
    // access port
    sec_store_if.store  port
);
    // three banks of 256 bytes; contents are non-volatile, so no reset
    logic [7:0] mem [0:767];
    logic [7:0] rdata_r;

    // program only clears bits, so a write with prog set ands with the old byte
    wire [7:0] wr_val = port.prog ? (mem[port.addr] & port.wdata)
                                  : port.wdata;

    always_ff @(posedge i_clk) begin
        if (port.we) begin
            mem[port.addr] <= wr_val;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= mem[port.addr];
        end
    end

    assign port.rdata = rdata_r;
endmodule

// *** dv/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
    // link to device
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi,
    input  wire logic i_miso,
    input  wire logic i_miso_oe
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end

    // taken late in the high phase, clear of the device's update delay
    task automatic tick(input logic b, output logic r);
        o_mosi = b;
        #200 o_sclk = 1'b1;
        #200 r = i_miso_oe ? i_miso : 1'bx;
        o_sclk = 1'b0;
    endtask

    task automatic frame(input logic [7:0] op, input logic [23:0] a,
                         input int pad, input int nrd);
        logic [31:0] sh;
        logic [7:0]  d;
        logic        r;
        sh = {op, a};
        o_cs_n = 1'b0;
        #200;
        for (int i = 31; i >= 0; i--) tick(sh[i], r);
        for (int i = 0; i < pad; i++) tick(~o_mosi, r);
        while (tx_q.size() > 0) begin
            d = tx_q.pop_front();
            for (int i = 7; i >= 0; i--) tick(d[i], r);
        end
        for (int k = 0; k < nrd; k++) begin
            for (int i = 7; i >= 0; i--) begin
                tick(~o_mosi, r);
                d[i] = r;
            end
            rx_q.push_back(d);
        end
        #100 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #600;
    endtask
endmodule

// *** dv/aux_cmd_checker_sva.sv ***
`timescale 1ns/1ps
module aux_cmd_checker #(
    parameter int ERASE_CYCLES = 1000
) (
    input wire logic       I_CLOCK,
    input wire logic       I_RESETN,
    input wire logic       I_CHIP_SELECT_N,
    input wire logic       I_SERIAL_CLK,
    input wire logic       I_WRITE_LATCH_FLAG,
    input wire logic       I_PER_REGION_PROTECT_SELECT,
    input wire logic       I_PROTECT_COMPLEMENT,
    input wire logic [2:0] I_PROTECT_EXTENT_BITS,
    input wire logic       O_SERIAL_OUT,
    input wire logic       O_SERIAL_OUT_OE,
    input wire logic       O_WRITE_LATCH_CLEAR,
    input wire logic       O_BUSY,
    input wire logic       O_CHECK_PROTECTED
);
    logic [31:0] busy_cnt_r;
    logic [31:0] busy_cnt_nxt;

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RESETN);

    assign busy_cnt_nxt = O_BUSY ? busy_cnt_r + 32'h0000_0001 : '0;

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    oe_deselect_a: assert property (
        I_CHIP_SELECT_N [*6] |-> !O_SERIAL_OUT_OE)
        else $error("output enabled while deselected");
    oe_not_busy_a: assert property (
        $rose(O_SERIAL_OUT_OE) |-> !O_BUSY && !I_CHIP_SELECT_N)
        else $error("read answered while busy");
    out_after_fall_a: assert property (
        O_SERIAL_OUT_OE && $past(O_SERIAL_OUT_OE) && $changed(O_SERIAL_OUT)
        |-> !$past(I_SERIAL_CLK, 2))
        else $error("data bit changed after a rising edge");
    clear_latch_a: assert property (
        O_WRITE_LATCH_CLEAR |-> I_WRITE_LATCH_FLAG)
        else $error("write accepted without latch flag");
    clear_deselect_a: assert property (
        O_WRITE_LATCH_CLEAR |-> I_CHIP_SELECT_N && $past(I_CHIP_SELECT_N, 2))
        else $error("write accepted before deselect");
    busy_start_a: assert property (
        $rose(O_BUSY) |-> I_WRITE_LATCH_FLAG && I_CHIP_SELECT_N)
        else $error("erase started wrongly");
    busy_time_a: assert property (
        O_BUSY ##1 !O_BUSY |-> busy_cnt_r == 32'(ERASE_CYCLES))
        else $error("erase length wrong");
    busy_quiet_a: assert property (
        O_BUSY && $past(O_BUSY, 2) |-> !O_WRITE_LATCH_CLEAR)
        else $error("command taken while busy");
    lock_protect_a: assert property (
        I_PER_REGION_PROTECT_SELECT [*2] |-> O_CHECK_PROTECTED)
        else $error("locked region reported open");
    extent_none_a: assert property (
        (!I_PER_REGION_PROTECT_SELECT && !I_PROTECT_COMPLEMENT
         && I_PROTECT_EXTENT_BITS == 3'h0) [*2] |-> !O_CHECK_PROTECTED)
        else $error("empty extent reported protected");
    extent_comp_a: assert property (
        (!I_PER_REGION_PROTECT_SELECT && I_PROTECT_COMPLEMENT
         && I_PROTECT_EXTENT_BITS == 3'h0) [*2] |-> O_CHECK_PROTECTED)
        else $error("complemented extent reported open");
endmodule

bind serial_flash_aux_space_commands aux_cmd_checker #(
    .ERASE_CYCLES(ERASE_CYCLES)
) chk_u (
    .I_CLOCK                    (I_CLOCK),
    .I_RESETN                   (I_RESETN),
    .I_CHIP_SELECT_N            (I_CHIP_SELECT_N),
    .I_SERIAL_CLK               (I_SERIAL_CLK),
    .I_WRITE_LATCH_FLAG         (I_WRITE_LATCH_FLAG),
    .I_PER_REGION_PROTECT_SELECT(I_PER_REGION_PROTECT_SELECT),
    .I_PROTECT_COMPLEMENT       (I_PROTECT_COMPLEMENT),
    .I_PROTECT_EXTENT_BITS      (I_PROTECT_EXTENT_BITS),
    .O_SERIAL_OUT               (O_SERIAL_OUT),
    .O_SERIAL_OUT_OE            (O_SERIAL_OUT_OE),
    .O_WRITE_LATCH_CLEAR        (O_WRITE_LATCH_CLEAR),
    .O_BUSY                     (O_BUSY),
    .O_CHECK_PROTECTED          (O_CHECK_PROTECTED)
);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import aux_flash_pkg::*;
    localparam int ERASE_N = 1000;
    logic        clk, rst_n, wl, sel, inv, so, oe, clr, busy, prot;
    logic        cs_n, sclk, mosi, gran, bottom;
    logic [2:0]  otp, extent;
    logic [23:0] q_addr;
    int          miscompares, total_checks, clr_cnt;

    serial_flash_aux_space_commands #(.ERASE_CYCLES(ERASE_N)) dut_u (
        .I_CLOCK(clk), .I_RESETN(rst_n), .I_CHIP_SELECT_N(cs_n),
        .I_SERIAL_CLK(sclk), .I_SERIAL_IN_PIN(mosi), .O_SERIAL_OUT(so),
        .O_SERIAL_OUT_OE(oe), .I_WRITE_LATCH_FLAG(wl),
        .I_OTP_LOCK_BITS(otp), .O_WRITE_LATCH_CLEAR(clr), .O_BUSY(busy),
        .I_PER_REGION_PROTECT_SELECT(sel), .I_PROTECT_COMPLEMENT(inv),
        .I_SECTOR_GRANULARITY_BIT(gran), .I_TOP_BOTTOM_SELECT(bottom),
        .I_PROTECT_EXTENT_BITS(extent), .I_CHECK_ADDR(q_addr),
        .O_CHECK_PROTECTED(prot));
    spi_host_model host_u (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
        .i_miso(so), .i_miso_oe(oe));

    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] op, input logic [23:0] a,
                         input int n, input logic [31:0] e);
        host_u.frame(op, a, 8, n);
        for (int k = 0; k < n; k++) chk(host_u.rx_q.pop_front(),
                                        e[31-8*k -: 8]);
    endtask

    task automatic erase_chk(input logic [23:0] a, input int pad,
                             input logic e);
        host_u.frame(OP_SEC_ERASE, a, pad, 0);
        repeat (4) @(negedge clk);
        chk({7'h00, busy}, {7'h00, e});
    endtask

    task automatic prog(input logic [23:0] a, input logic [23:0] d);
        host_u.tx_q = '{d[23:16], d[15:8], d[7:0]};
        host_u.frame(OP_SEC_PROG, a, 0, 0);
    endtask

    always @(posedge clk) if (clr === 1'b1) clr_cnt++;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #4000000;
        miscompares++;
        wrap_up();
    end

    initial begin
        logic [23:0] ra;
        int          n;
        {rst_n, wl, sel, inv, gran, bottom} = 6'h00;
        {otp, extent, q_addr} = '0;
        {miscompares, total_checks, clr_cnt} = '0;
        sel = 1'b1;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk({6'h00, busy, oe}, 8'h00);
        chk({7'h00, prot}, 8'h01);
        rdchk(OP_SFDP_READ, 24'h00_0000, 4, 32'h5346_4450);
        rdchk(OP_SFDP_READ, 24'h00_00FE, 3, 32'hFFFF_53FF);
        rdchk(OP_SFDP_READ, 24'h01_0000, 1, 32'hxxxx_xxxx);
        erase_chk(24'h00_1000, 0, 1'b0);
        wl = 1'b1;
        erase_chk(24'h00_1000, 1, 1'b0);
        erase_chk(24'h00_1100, 0, 1'b0);
        erase_chk(24'h00_4000, 0, 1'b0);
        for (int r = 1; r <= 3; r++) begin
            ra = {8'h00, 4'(r), 12'h0FF};
            erase_chk(ra, 0, 1'b1);
            rdchk(OP_SEC_READ, ra, 1, 32'hxxxx_xxxx);
            chk({7'h00, busy}, 8'h01);
            n = 0;
            while (busy !== 1'b0 && n < 2 * ERASE_N) begin
                @(negedge clk);
                n++;
            end
            chk({7'h00, busy}, 8'h00);
            rdchk(OP_SEC_READ, ra, 2, 32'hFFFF_FFFF);
        end
        chk(clr_cnt[7:0], 8'h03);
        wl = 1'b0;
        prog(24'h00_1000, 24'h00_0000);
        wl = 1'b1;
        prog(24'h00_10FE, 24'hA5_3C96);
        rdchk(OP_SEC_READ, 24'h00_10FE, 4, 32'hA53C_96FF);
        otp = 3'h4;
        erase_chk(24'h00_3000, 0, 1'b0);
        prog(24'h00_3005, 24'h00_0000);
        rdchk(OP_SEC_READ, 24'h00_3005, 3, 32'hFFFF_FFFF);
        wl = 1'b0;
        host_u.frame(OP_BLOCK_LOCK, 24'h05_0000, 0, 0);
        chk(clr_cnt[7:0], 8'h04);
        wl = 1'b1;
        host_u.frame(OP_BLOCK_LOCK, 24'h05_0000, 0, 0);
        chk(clr_cnt[7:0], 8'h05);
        q_addr = 24'h05_0000;
        repeat (2) @(negedge clk);
        chk({7'h00, prot}, 8'h01);
        sel = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h00, prot}, 8'h00);
        inv = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, prot}, 8'h01);
        // bottom eight blocks, then the top ones, then two bottom sectors
        extent = 3'h2;
        bottom = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, prot}, 8'h00);
        inv = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h00, prot}, 8'h01);
        bottom = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h00, prot}, 8'h00);
        {gran, bottom, q_addr} = {2'b11, 24'h00_1000};
        repeat (2) @(negedge clk);
        chk({7'h00, prot}, 8'h01);
        // six bytes pass through the four-deep buffer
        host_u.tx_q = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
        host_u.frame(OP_SEC_PROG, 24'h00_2010, 0, 0);
        rdchk(OP_SEC_READ, 24'h00_2010, 4, 32'h1122_3344);
        rdchk(OP_SEC_READ, 24'h00_2014, 4, 32'h5566_FFFF);
        chk(clr_cnt[7:0], 8'h06);
        wrap_up();
    end
endmodule
